// File: dv/afe_bank_props.sv
/* Port checker for the front-end control bank.
   Assumes the bank header and one ref_clk domain with sync reset. */
`include "afe_ctrl_map.vh"
`default_nettype none
// ****************
// Port checker
// ****************
module afe_bank_props #(
  parameter ADDR_W = 4,
  parameter DATA_W = 8
) (
  input wire logic              ref_clk,
  input wire logic              reset,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_write,
  input wire logic              reg_read,
  input wire logic [DATA_W-1:0] reg_rdata_ff,
  input wire logic              sample_sync_pin,
  input wire logic [3:0]        converter_nibble,
  input wire logic              video_sample_clock,
  input wire logic              converter_clock,
  input wire logic              reset_sample_clock,
  input wire logic              timing_sync,
  input wire logic [3:0]        output_nibble_ff,
  input wire logic [7:0]        active_offset_ff,
  input wire logic [7:0]        active_gain_ff,
  input wire logic              colour_reserved_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       en_ff;
  logic       pol_ff;
  logic [2:0] dly_ff;
  logic       tst_ff;
  logic [1:0] sel_ff;
  logic [3:0] strobes;
  logic       res_sel;
  assign strobes = {timing_sync, video_sample_clock, converter_clock,
                    reset_sample_clock};
  assign res_sel = (sel_ff == 2'h3);
  // Shadow of mode fields; bus writes and reset are the only way they change
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      en_ff <= 1'b0;
      pol_ff <= 1'b0;
      dly_ff <= 3'h0;
      tst_ff <= 1'b0;
      sel_ff <= 2'h0;
    end else if (reg_write) begin
      case (reg_addr)
        `ADDR_SYNC_SETUP: begin
          en_ff <= reg_wdata[`SYNC_ENABLE_BIT];
          pol_ff <= reg_wdata[`SYNC_POLARITY_BIT];
          dly_ff <= reg_wdata[`SYNC_DELAY_MSB:`SYNC_DELAY_LSB];
        end
        `ADDR_CLOCK_TEST: tst_ff <= reg_wdata[`CLOCK_TEST_BIT];
        `ADDR_COLOUR_SELECT:
          sel_ff <= reg_wdata[`COLOUR_SEL_MSB:`COLOUR_SEL_LSB];
        default: ;
      endcase
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  AST_BYPASS: assert property (!en_ff |->
    timing_sync == $past(sample_sync_pin, 2)) else $error("bypass lag");
  AST_DET_D0: assert property (en_ff && dly_ff == 3'h0 &&
    (pol_ff ? $rose(sample_sync_pin) : $fell(sample_sync_pin))
    |-> ##3 timing_sync) else $error("sync pulse late");
  AST_WRONG_EDGE: assert property (en_ff &&
    (pol_ff ? $fell(sample_sync_pin) : $rose(sample_sync_pin))
    |-> ##3 !timing_sync) else $error("pulse on wrong edge");
  AST_NIB_DATA: assert property (!tst_ff |=>
    output_nibble_ff == $past(converter_nibble)) else $error("data out");
  AST_NIB_TEST: assert property (tst_ff |=>
    output_nibble_ff == $past(strobes)) else $error("test out");
  AST_ALL_OFF: assert property (reg_write && sel_ff != 2'h3 &&
    reg_addr == `ADDR_ALL_OFFSET |-> ##2
    active_offset_ff == $past(reg_wdata, 2)) else $error("all offset");
  AST_ALL_GAIN: assert property (reg_write && sel_ff != 2'h3 &&
    reg_addr == `ADDR_ALL_GAIN |-> ##2
    active_gain_ff == $past(reg_wdata, 2)) else $error("all gain");
  AST_RESERVED: assert property (1'b1 |=>
    colour_reserved_ff == $past(res_sel)) else $error("reserved flag");
  AST_RST_CODES: assert property ($fell(reset) |->
    active_offset_ff == `RST_OFFSET_CODE &&
    active_gain_ff == `RST_GAIN_CODE) else $error("code reset");
  AST_COMMON_RD: assert property (reg_read &&
    (reg_addr == `ADDR_ALL_OFFSET || reg_addr == `ADDR_ALL_GAIN)
    |=> reg_rdata_ff == `READ_UNMAPPED) else $error("common read");
endmodule
bind afe_sync_test_gain_registers afe_bank_props #(
  .ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_props (
  .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata_ff(reg_rdata_ff), .sample_sync_pin(sample_sync_pin),
  .converter_nibble(converter_nibble),
  .video_sample_clock(video_sample_clock),
  .converter_clock(converter_clock),
  .reset_sample_clock(reset_sample_clock), .timing_sync(timing_sync),
  .output_nibble_ff(output_nibble_ff),
  .active_offset_ff(active_offset_ff), .active_gain_ff(active_gain_ff),
  .colour_reserved_ff(colour_reserved_ff));
`default_nettype wire

// File: dv/scan_ctrl_model.sv
/* Scanner timing controller: sync pin, timing strobes, converter data.
   Assumes the bank samples all of these on ref_clk. */
`default_nettype none
// ****************
// Timing controller
// ****************
module scan_ctrl_model (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  output var  logic       sync_ff,
  output var  logic [6:0] cnt_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  initial sync_ff = 1'b0;
  // Free count: low bits are strobes, high bits are data, held at zero while reset is high
  always @(posedge ref_clk) begin
    if (reset)
      cnt_ff <= 7'h00;
    else
      cnt_ff <= cnt_ff + 7'h01;
  end
  // Sync level changes just after an edge, as the real driver does
  task drive_sync(input logic lvl);
    @(posedge ref_clk);
    sync_ff <= lvl;
  endtask
endmodule
`default_nettype wire

// File: dv/test_afe_sync_test_gain_registers.sv
/* Directed bench for the front-end control bank over its register port.
   Assumes the bank header, the port checker and the controller model. */
`include "afe_ctrl_map.vh"
`default_nettype none
// ****************
// Bench top
// ****************
module test_afe_sync_test_gain_registers;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk = 1'b0;
  logic       reset = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_write = 1'b0;
  logic       reg_read = 1'b0;
  wire  [7:0] rdata;
  wire  [3:0] nib;
  wire  [7:0] offs;
  wire  [7:0] gain;
  wire        tsync;
  wire        resv;
  wire        pin;
  wire  [6:0] cnt;
  logic [6:0] prev_cnt;
  int         err_total = 0;
  int         samples_checked = 0;
  int         i;
  always #4 ref_clk = ~ref_clk;
  scan_ctrl_model u_ctrl (.ref_clk(ref_clk), .reset(reset),
    .sync_ff(pin), .cnt_ff(cnt));
  afe_sync_test_gain_registers u_dut (.ref_clk(ref_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata_ff(rdata), .sample_sync_pin(pin),
    .converter_nibble(cnt[6:3]), .video_sample_clock(cnt[0]),
    .converter_clock(cnt[1]), .reset_sample_clock(cnt[2]),
    .timing_sync(tsync), .output_nibble_ff(nib), .active_offset_ff(offs),
    .active_gain_ff(gain), .colour_reserved_ff(resv));
  // Compare and count
  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One-cycle strobes; data stands only in the cycle after a read
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  // Sync edge, then first high cycle and count of high cycles
  task meas(input logic lvl, input int f, input int c);
    int first;
    int hits;
    first = 0;
    hits = 0;
    u_ctrl.drive_sync(lvl);
    for (int k = 1; k <= 14; k++) begin
      @(posedge ref_clk);
      #1;
      if (tsync === 1'b1) begin
        hits++;
        if (first == 0) first = k;
      end
    end
    chk(8'(first), 8'(f));
    chk(8'(hits), 8'(c));
  endtask
  task wrap_up;
    if (err_total == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Whole run is a few hundred cycles; this is ample margin
  initial begin
    #20000;
    err_total++;
    wrap_up();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    for (i = 0; i < 10; i++)
      rd(4'(i), (i > 2 && i < 6) ? 8'h80 : 8'h00);
    for (i = 0; i < 3; i++) begin
      wr(4'(3 + i), 8'h10 + 8'(i));
      wr(4'(7 + i), 8'h40 + 8'(i));
    end
    // Select 11 keeps the blue pair in use
    for (i = 0; i < 4; i++) begin
      wr(`ADDR_COLOUR_SELECT, 8'(i * 16));
      repeat (3) @(posedge ref_clk);
      #1 chk(offs, 8'h10 + 8'(i > 2 ? 2 : i));
      chk(gain, 8'h40 + 8'(i > 2 ? 2 : i));
      chk(8'(resv), 8'(i == 3));
    end
    wr(`ADDR_COLOUR_SELECT, 8'h00);
    wr(`ADDR_ALL_OFFSET, 8'h5A);
    wr(`ADDR_ALL_GAIN, 8'hA5);
    for (i = 0; i < 3; i++) begin
      rd(4'(3 + i), 8'h5A);
      rd(4'(7 + i), 8'hA5);
    end
    rd(`ADDR_ALL_GAIN, `READ_UNMAPPED);
    rd(4'hB, `READ_UNMAPPED);
    wr(`ADDR_CLOCK_TEST, 8'h80);
    rd(`ADDR_CLOCK_TEST, 8'h80);
    // Test mode: pin 3 carries idle sync, pins 2:0 last cycle's strobes
    @(posedge ref_clk);
    #1 prev_cnt = cnt - 7'h01;
    chk(8'(nib), {5'h00, prev_cnt[0], prev_cnt[1], prev_cnt[2]});
    wr(`ADDR_SYNC_SETUP, 8'h1E);
    rd(`ADDR_SYNC_SETUP, 8'h1E);
    meas(1'b1, 2, 13);
    meas(1'b0, 1, 1);
    wr(`ADDR_SYNC_SETUP, 8'h11);
    meas(1'b1, 3, 1);
    meas(1'b0, 0, 0);
    wr(`ADDR_SYNC_SETUP, 8'h0F);
    meas(1'b1, 0, 0);
    meas(1'b0, 10, 1);
    wr(`ADDR_CLOCK_TEST, 8'h00);
    repeat (4) @(posedge ref_clk);
    // Data mode: nibble is the converter data of the cycle before
    #1 prev_cnt = cnt - 7'h01;
    chk(8'(nib), 8'(prev_cnt[6:3]));
    // Mid-run reset must bring written codes back to their defaults
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    rd(`ADDR_RED_OFFSET, `RST_OFFSET_CODE);
    rd(`ADDR_BLUE_GAIN, `RST_GAIN_CODE);
    chk(offs, `RST_OFFSET_CODE);
    chk(gain, `RST_GAIN_CODE);
    wrap_up();
  end
endmodule
`default_nettype wire

// File: hdl/afe_sync_test_gain_registers.v
/*
 * Control register bank of a scanner front end: sync input path, clock
 * test output mux, per-colour offset and gain codes.
 * Assumes a register master on ref_clk and asynchronous pins for sync.
 */
`include "afe_ctrl_map.vh"
`default_nettype none

module afe_sync_test_gain_registers #(
  parameter ADDR_W = 4,
  parameter DATA_W = 8
) (
  input  wire              ref_clk,
  input  wire              reset,
  input  wire [ADDR_W-1:0] reg_addr,
  input  wire [DATA_W-1:0] reg_wdata,
  input  wire              reg_write,
  input  wire              reg_read,
  output reg  [DATA_W-1:0] reg_rdata_ff,
  input  wire              sample_sync_pin,
  input  wire [3:0]        converter_nibble,
  input  wire              video_sample_clock,
  input  wire              converter_clock,
  input  wire              reset_sample_clock,
  output wire              timing_sync,
  output reg  [3:0]        output_nibble_ff,
  output reg  [7:0]        active_offset_ff,
  output reg  [7:0]        active_gain_ff,
  output reg               colour_reserved_ff
);

  // ****************************************************************
  // Register storage
  // ****************************************************************
  reg  [7:0] sync_detect_setup_ff;
  reg  [7:0] clock_test_control_ff;
  reg  [7:0] colour_select_reg_ff;
  reg  [7:0] offset_code_ff [0:2];
  reg  [7:0] gain_code_ff   [0:2];
  reg        sync_meta_ff;
  reg        sync_level_ff;
  wire       internal_sync_pulse;
  wire       sync_detect_enable;
  wire [2:0] sync_delay;
  wire       sync_edge_polarity;
  wire       clock_test_select;
  wire [1:0] colour_select;
  reg  [7:0] nxt_rdata;
  reg  [3:0] nxt_nibble;
  genvar     gi;

  // Colour-select field to storage index; 11 reserved
  function [1:0] colour_index;
    input [1:0] sel;
    begin
      case (sel)
        `COLOUR_RED:   colour_index = 2'h0;
        `COLOUR_GREEN: colour_index = 2'h1;
        `COLOUR_BLUE:  colour_index = 2'h2;
        default:       colour_index = 2'h3;
      endcase
    end
  endfunction

  assign sync_detect_enable = sync_detect_setup_ff[`SYNC_ENABLE_BIT];
  assign sync_delay         =
    sync_detect_setup_ff[`SYNC_DELAY_MSB:`SYNC_DELAY_LSB];
  assign sync_edge_polarity = sync_detect_setup_ff[`SYNC_POLARITY_BIT];
  assign clock_test_select  = clock_test_control_ff[`CLOCK_TEST_BIT];
  assign colour_select      =
    colour_select_reg_ff[`COLOUR_SEL_MSB:`COLOUR_SEL_LSB];

  // ****************************************************************
  // Single-register writes
  // ****************************************************************
  // Sync setup bits 7:5 are stored as zero even if the controller breaks its side
  always @(posedge ref_clk) begin
    if (reset) begin
      sync_detect_setup_ff  <= `RST_SYNC_SETUP;
      clock_test_control_ff <= `RST_CLOCK_TEST;
      colour_select_reg_ff  <= `RST_COLOUR_SELECT;
    end else if (reg_write) begin
      case (reg_addr)
        `ADDR_SYNC_SETUP:
          sync_detect_setup_ff <= reg_wdata & `SYNC_SETUP_MASK;
        `ADDR_CLOCK_TEST:    clock_test_control_ff <= reg_wdata;
        `ADDR_COLOUR_SELECT: colour_select_reg_ff  <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Per-colour codes with broadcast writes
  // ****************************************************************
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_colour
      // Own addresses summed as integers, cut to bus width on purpose
      localparam integer OFF_SUM  = `ADDR_RED_OFFSET + gi;
      localparam integer GAIN_SUM = `ADDR_RED_GAIN + gi;
      // Own address or the common location loads this colour
      always @(posedge ref_clk) begin
        if (reset) begin
          offset_code_ff[gi] <= `RST_OFFSET_CODE;
          gain_code_ff[gi]   <= `RST_GAIN_CODE;
        end else if (reg_write) begin
          if (reg_addr == `ADDR_ALL_OFFSET ||
              reg_addr == OFF_SUM[ADDR_W-1:0]) begin
            offset_code_ff[gi] <= reg_wdata;
          end
          if (reg_addr == `ADDR_ALL_GAIN ||
              reg_addr == GAIN_SUM[ADDR_W-1:0]) begin
            gain_code_ff[gi] <= reg_wdata;
          end
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Read port
  // ****************************************************************
  // Common locations hold nothing; they read as the unmapped value
  always @* begin
    case (reg_addr)
      `ADDR_SYNC_SETUP:    nxt_rdata = sync_detect_setup_ff;
      `ADDR_CLOCK_TEST:    nxt_rdata = clock_test_control_ff;
      `ADDR_COLOUR_SELECT: nxt_rdata = colour_select_reg_ff;
      `ADDR_RED_OFFSET:    nxt_rdata = offset_code_ff[0];
      `ADDR_GREEN_OFFSET:  nxt_rdata = offset_code_ff[1];
      `ADDR_BLUE_OFFSET:   nxt_rdata = offset_code_ff[2];
      `ADDR_RED_GAIN:      nxt_rdata = gain_code_ff[0];
      `ADDR_GREEN_GAIN:    nxt_rdata = gain_code_ff[1];
      `ADDR_BLUE_GAIN:     nxt_rdata = gain_code_ff[2];
      default:             nxt_rdata = `READ_UNMAPPED;
    endcase
  end

  // Data valid only in the cycle after the strobe
  always @(posedge ref_clk) begin
    if (reset) begin
      reg_rdata_ff <= {DATA_W{1'b0}};
    end else if (reg_read) begin
      reg_rdata_ff <= nxt_rdata;
    end else begin
      reg_rdata_ff <= {DATA_W{1'b0}};
    end
  end

  // ****************************************************************
  // Sample-sync path
  // ****************************************************************
  // Two-stage synchroniser; the pin is asynchronous to ref_clk
  always @(posedge ref_clk) begin
    if (reset) begin
      sync_meta_ff  <= 1'b0;
      sync_level_ff <= 1'b0;
    end else begin
      sync_meta_ff  <= sample_sync_pin;
      sync_level_ff <= sync_meta_ff;
    end
  end

  sync_edge_delay #(
    .DELAY_W      (3)
  ) u_edge (
    .ref_clk      (ref_clk),
    .reset        (reset),
    .sync_level   (sync_level_ff),
    .rising_sel   (sync_edge_polarity),
    .delay_cycles (sync_delay),
    .pulse_ff     (internal_sync_pulse)
  );

  // Bypass makes delay and polarity irrelevant
  assign timing_sync = sync_detect_enable ? internal_sync_pulse
                                          : sync_level_ff;

  // ****************************************************************
  // Output nibble mux and active code selection
  // ****************************************************************
  always @* begin
    if (clock_test_select) begin
      nxt_nibble = {timing_sync, video_sample_clock,
                    converter_clock, reset_sample_clock};
    end else begin
      nxt_nibble = converter_nibble;
    end
  end

  // Reserved select keeps the last valid colour applied
  always @(posedge ref_clk) begin
    if (reset) begin
      output_nibble_ff   <= 4'h0;
      active_offset_ff   <= `RST_OFFSET_CODE;
      active_gain_ff     <= `RST_GAIN_CODE;
      colour_reserved_ff <= 1'b0;
    end else begin
      output_nibble_ff   <= nxt_nibble;
      colour_reserved_ff <= (colour_index(colour_select) == 2'h3);
      if (colour_index(colour_select) != 2'h3) begin
        active_offset_ff <= offset_code_ff[colour_index(colour_select)];
        active_gain_ff   <= gain_code_ff[colour_index(colour_select)];
      end
    end
  end

endmodule

`default_nettype wire

// File: hdl/sync_edge_delay.v
/*
 * Sample-sync edge detector with programmable delay in master clocks.
 * Assumes sync_level is already synchronised to ref_clk.
 */
`default_nettype none

// Detects the chosen edge, then pulses after delay_cycles clocks
module sync_edge_delay #(
  parameter DELAY_W = 3
) (
  input  wire               ref_clk,
  input  wire               reset,
  input  wire               sync_level,
  input  wire               rising_sel,
  input  wire [DELAY_W-1:0] delay_cycles,
  output reg                pulse_ff
);

  reg               prev_ff;
  reg [DELAY_W-1:0] count_ff;
  reg               busy_ff;
  wire              edge_seen;

  // Polarity selects rising or falling edge
  assign edge_seen = rising_sel ? (sync_level & ~prev_ff)
                                : (~sync_level & prev_ff);

  // A new edge restarts the count; zero delay fires at once
  always @(posedge ref_clk) begin
    if (reset) begin
      prev_ff  <= 1'b0;
      count_ff <= {DELAY_W{1'b0}};
      busy_ff  <= 1'b0;
      pulse_ff <= 1'b0;
    end else begin
      prev_ff  <= sync_level;
      pulse_ff <= 1'b0;
      if (edge_seen) begin
        if (delay_cycles == {DELAY_W{1'b0}}) begin
          pulse_ff <= 1'b1;
          busy_ff  <= 1'b0;
        end else begin
          count_ff <= delay_cycles - {{(DELAY_W-1){1'b0}}, 1'b1};
          busy_ff  <= 1'b1;
        end
      end else if (busy_ff) begin
        if (count_ff == {DELAY_W{1'b0}}) begin
          pulse_ff <= 1'b1;
          busy_ff  <= 1'b0;
        end else begin
          count_ff <= count_ff - {{(DELAY_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

`default_nettype wire

// File: pkg/afe_ctrl_map.vh
/*
 * Register offsets, field positions and reset values of
 * the front-end control bank (sync path, clock test mux, offset / gain).
 * Assumes inclusion by bare name from design files; definitions only.
 */
`ifndef AFE_CTRL_MAP_VH
`define AFE_CTRL_MAP_VH

// ****************************************************************
// Register offsets (plain register port, 8-bit data, 4-bit address)
// ****************************************************************
`define ADDR_SYNC_SETUP      4'h0
`define ADDR_CLOCK_TEST      4'h1
`define ADDR_COLOUR_SELECT   4'h2
`define ADDR_RED_OFFSET      4'h3
`define ADDR_GREEN_OFFSET    4'h4
`define ADDR_BLUE_OFFSET     4'h5
`define ADDR_ALL_OFFSET      4'h6
`define ADDR_RED_GAIN        4'h7
`define ADDR_GREEN_GAIN      4'h8
`define ADDR_BLUE_GAIN       4'h9
`define ADDR_ALL_GAIN        4'hA

// ****************************************************************
// Field positions
// ****************************************************************
`define SYNC_ENABLE_BIT      0
`define SYNC_DELAY_LSB       1
`define SYNC_DELAY_MSB       3
`define SYNC_POLARITY_BIT    4
`define CLOCK_TEST_BIT       7
`define COLOUR_SEL_LSB       4
`define COLOUR_SEL_MSB       5

// ****************************************************************
// Reset values and codes
// ****************************************************************
`define RST_SYNC_SETUP       8'h00
`define RST_CLOCK_TEST       8'h00
`define RST_COLOUR_SELECT    8'h00
`define RST_OFFSET_CODE      8'h80
`define RST_GAIN_CODE        8'h00
`define READ_UNMAPPED        8'h00
`define COLOUR_RED           2'h0
`define COLOUR_GREEN         2'h1
`define COLOUR_BLUE          2'h2
`define SYNC_SETUP_MASK      8'h1F

`endif
